// ### scio_top.sv
// Servo command and status I/O block with APB register access.
// Assumes all pin inputs are synchronous to pclk and active high.
`timescale 1ns/10ps
module scio_top #(
  parameter int SETTLE_CYC = scio_pkg::SCIO_EN_SETTLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic servo_enable_input,
  input wire logic command_pulse_inhibit,
  input wire logic forward_limit_input,
  input wire logic reverse_limit_input,
  input wire logic alarm_clear_input,
  input wire logic mode_input,
  input wire logic pulse_in,
  input wire logic sign_in,
  input wire logic motor_enc_a,
  input wire logic motor_enc_b,
  input wire logic motor_enc_z,
  input wire logic alarm_event,
  output logic drive_enabled,
  output logic settle_done,
  output logic speed_control,
  output logic internal_speed_sel,
  output logic [15:0] speed_value,
  output logic internal_start,
  output logic servo_alarm,
  output logic encoder_a_output_p,
  output logic encoder_a_output_n,
  output logic encoder_b_output_p,
  output logic encoder_b_output_n,
  output logic encoder_index_output_p,
  output logic encoder_index_output_n,
  output logic zero_mark_oc_output,
  output logic zero_mark_oc_oe_n,
  output logic irq
);
  import scio_pkg::*;

  // --------------------------------------------------------------------------
  // Registers and state
  // --------------------------------------------------------------------------
  logic [31:0] ctrl;
  logic [15:0] internal_speed_param;
  logic [15:0] encoder_divider_param;
  logic [31:0] position_acc;
  logic [SCIO_NIRQ-1:0] irq_stat;
  logic [SCIO_NIRQ-1:0] irq_mask;
  logic [SCIO_NIRQ-1:0] irq_event;
  logic [7:0] alarm_record;
  logic [31:0] settle_cnt;
  logic enc_a_d;
  logic enc_b_d;

  logic enable_override_param;
  logic [1:0] inhibit_config_param;
  logic [1:0] limit_config_param;
  logic [2:0] mode_function_param;
  logic [1:0] pulse_format;
  logic [7:0] alarm_code;

  // Control register fields
  assign enable_override_param = ctrl[SCIO_C_OVR];
  assign inhibit_config_param = ctrl[SCIO_C_INH +: 2];
  assign limit_config_param = ctrl[SCIO_C_LIM +: 2];
  assign mode_function_param = ctrl[SCIO_C_MODE +: 3];
  assign pulse_format = ctrl[SCIO_C_FMT +: 2];
  assign alarm_code = ctrl[SCIO_C_ALM +: 8];

  // Access strobes; every access completes with no wait state
  logic wr_en;
  assign wr_en = psel & penable & pwrite;
  assign pready = 1'b1;

  // --------------------------------------------------------------------------
  // Input edges
  // --------------------------------------------------------------------------
  logic pul_r, pul_f, sig_r, sig_f, clr_r, md_r;
  logic ea_r, ea_f, eb_r, eb_f;

  scio_edge u_pul (.pclk(pclk), .presetn(presetn), .din(pulse_in),
    .rise(pul_r), .fall(pul_f));
  scio_edge u_sig (.pclk(pclk), .presetn(presetn), .din(sign_in),
    .rise(sig_r), .fall(sig_f));
  scio_edge u_clr (.pclk(pclk), .presetn(presetn), .din(alarm_clear_input),
    .rise(clr_r), .fall());
  scio_edge u_md (.pclk(pclk), .presetn(presetn), .din(mode_input),
    .rise(md_r), .fall());
  scio_edge u_ea (.pclk(pclk), .presetn(presetn), .din(motor_enc_a),
    .rise(ea_r), .fall(ea_f));
  scio_edge u_eb (.pclk(pclk), .presetn(presetn), .din(motor_enc_b),
    .rise(eb_r), .fall(eb_f));

  // --------------------------------------------------------------------------
  // Enable, limits and mode
  // --------------------------------------------------------------------------
  logic enabled_raw;
  logic fwd_block, rev_block;
  logic inhibit_block, inhibit_clear;

  // Override forces enable
  assign enabled_raw = enable_override_param | servo_enable_input;

  // Limit active in config 1 or 2
  assign fwd_block = forward_limit_input &&
    (limit_config_param == 2'h1 || limit_config_param == 2'h2);
  assign rev_block = reverse_limit_input &&
    (limit_config_param == 2'h1 || limit_config_param == 2'h2);

  // Inhibit behaviour by configuration
  assign inhibit_block = command_pulse_inhibit &&
    inhibit_config_param != 2'h0;
  assign inhibit_clear = command_pulse_inhibit &&
    inhibit_config_param == 2'h2;

  // Settle timer after enable; status only, controller keeps the wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt <= 32'h0000_0000;
      settle_done <= 1'b0;
    end else if (!enabled_raw) begin
      settle_cnt <= 32'h0000_0000;
      settle_done <= 1'b0;
    end else if (settle_cnt >= 32'(SETTLE_CYC - 1)) begin
      settle_done <= 1'b1;
    end else begin
      settle_cnt <= settle_cnt + 32'h0000_0001;
    end
  end

  // Registered drive status outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_enabled <= 1'b0;
      speed_control <= 1'b0;
      internal_speed_sel <= 1'b0;
      speed_value <= 16'h0000;
      internal_start <= 1'b0;
    end else begin
      drive_enabled <= enabled_raw;
      speed_control <= mode_function_param == SCIO_MF_POSSPD &&
        mode_input;
      internal_speed_sel <= mode_function_param == SCIO_MF_INTSPD &&
        mode_input;
      speed_value <= (mode_function_param == SCIO_MF_INTSPD && mode_input)
        ? internal_speed_param : 16'h0000;
      internal_start <= mode_function_param == SCIO_MF_INTPULSE &&
        md_r && enabled_raw;
    end
  end

  // --------------------------------------------------------------------------
  // Command pulse decoder
  // --------------------------------------------------------------------------
  logic step;
  logic dir_fwd;

  // Step and direction per format
  always_comb begin
    step = 1'b0;
    dir_fwd = 1'b1;
    case (pulse_format)
      SCIO_FMT_PS: begin
        step = pul_r;
        dir_fwd = ~sign_in;
      end
      SCIO_FMT_FR: begin
        step = pul_r | sig_r;
        dir_fwd = pul_r;
      end
      SCIO_FMT_AB: begin
        // Every edge counts; A leading B is forward
        step = pul_r | pul_f | sig_r | sig_f;
        dir_fwd = (pul_r | pul_f) ? (pulse_in != sign_in)
          : (pulse_in == sign_in);
      end
      default: begin
        step = 1'b0;
        dir_fwd = 1'b1;
      end
    endcase
  end

  // Step gating by enable, inhibit and travel limits
  logic accept;
  logic refused;
  assign refused = step && enabled_raw && !inhibit_block &&
    ((dir_fwd && fwd_block) || (!dir_fwd && rev_block));
  assign accept = step && enabled_raw && !inhibit_block && !refused;

  // Position accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      position_acc <= 32'h0000_0000;
    end else if (inhibit_clear || !enabled_raw) begin
      position_acc <= 32'h0000_0000;
    end else if (accept) begin
      position_acc <= dir_fwd ? position_acc + 32'h0000_0001
        : position_acc - 32'h0000_0001;
    end
  end

  // --------------------------------------------------------------------------
  // Alarm
  // --------------------------------------------------------------------------
  // Limit alarm only in limit config 1
  logic lim_alarm;
  assign lim_alarm = limit_config_param == 2'h1 &&
    (forward_limit_input || reverse_limit_input);

  // Alarm latch; a standing alarm wins over the clear edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      servo_alarm <= 1'b0;
      alarm_record <= 8'h00;
    end else if (alarm_event || lim_alarm) begin
      servo_alarm <= 1'b1;
      alarm_record <= alarm_event ? alarm_code : 8'hFF;
    end else if (clr_r) begin
      servo_alarm <= 1'b0;
      alarm_record <= 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // Encoder outputs
  // --------------------------------------------------------------------------
  // Motor encoder step and direction
  logic enc_step, enc_dir, ea_q, eb_q;
  assign enc_step = ea_r | ea_f | eb_r | eb_f;
  assign enc_dir = (ea_r | ea_f) ? (motor_enc_a != motor_enc_b)
    : (motor_enc_a == motor_enc_b);

  scio_encdiv u_div (.pclk(pclk), .presetn(presetn), .step(enc_step),
    .dir_fwd(enc_dir), .divider(encoder_divider_param),
    .enc_a(ea_q), .enc_b(eb_q));

  // Differential pairs and open-collector zero mark
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      encoder_a_output_p <= 1'b0;
      encoder_a_output_n <= 1'b1;
      encoder_b_output_p <= 1'b0;
      encoder_b_output_n <= 1'b1;
      encoder_index_output_p <= 1'b0;
      encoder_index_output_n <= 1'b1;
      zero_mark_oc_oe_n <= 1'b1;
    end else begin
      encoder_a_output_p <= ea_q;
      encoder_a_output_n <= ~ea_q;
      encoder_b_output_p <= eb_q;
      encoder_b_output_n <= ~eb_q;
      encoder_index_output_p <= motor_enc_z;
      encoder_index_output_n <= ~motor_enc_z;
      zero_mark_oc_oe_n <= ~motor_enc_z;
    end
  end
  assign zero_mark_oc_output = 1'b0;

  // --------------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------------
  // Interrupt sources, limits on onset only
  assign irq_event = {internal_start, refused, rev_block & ~enc_b_d,
    fwd_block & ~enc_a_d, alarm_event | lim_alarm};

  // Previous limit block levels for onset detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_a_d <= 1'b0;
      enc_b_d <= 1'b0;
    end else begin
      enc_a_d <= fwd_block;
      enc_b_d <= rev_block;
    end
  end

  // Set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~((wr_en && paddr == SCIO_IRQ_OFF) ?
        pwdata[SCIO_NIRQ-1:0] : '0)) | irq_event;
    end
  end
  assign irq = |(irq_stat & irq_mask);

  // --------------------------------------------------------------------------
  // APB registers
  // --------------------------------------------------------------------------
  // Writable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= SCIO_CTRL_RESET;
      internal_speed_param <= 16'h0000;
      encoder_divider_param <= SCIO_DIV_RESET;
      irq_mask <= '0;
    end else if (wr_en) begin
      case (paddr)
        SCIO_CTRL_OFF: ctrl <= pwdata & 32'h0003_FFFF;
        SCIO_SPEED_OFF: internal_speed_param <= pwdata[15:0];
        SCIO_DIV_OFF: encoder_divider_param <= pwdata[15:0];
        SCIO_MASK_OFF: irq_mask <= pwdata[SCIO_NIRQ-1:0];
        default: ;
      endcase
    end
  end

  // Error response for holes and unaligned addresses
  logic map_hit;
  assign map_hit = paddr[1:0] == 2'h0 && paddr <= SCIO_ALREC_OFF;
  assign pslverr = psel & penable & ~map_hit;

  // Read data, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        SCIO_CTRL_OFF: prdata <= ctrl;
        SCIO_SPEED_OFF: prdata <= {16'h0000, internal_speed_param};
        SCIO_DIV_OFF: prdata <= {16'h0000, encoder_divider_param};
        SCIO_STAT_OFF: prdata <= {24'h00_0000, settle_done, servo_alarm,
          rev_block, fwd_block, inhibit_block, speed_control,
          drive_enabled, mode_input};
        SCIO_POS_OFF: prdata <= position_acc;
        SCIO_IRQ_OFF: prdata <= {27'h000_0000, irq_stat};
        SCIO_MASK_OFF: prdata <= {27'h000_0000, irq_mask};
        SCIO_ALREC_OFF: prdata <= {24'h00_0000, alarm_record};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : scio_top

// ### scio_pkg.sv
// Package of constants for the servo command and status I/O block.
// Assumes a 125 MHz APB clock and 32-bit APB data.
//
// Summary of operation
// - Enable override set: servo enable input ignored, drive treated enabled.
// - Inhibit config 0 ignores inhibit input; 1 blocks pulses while active.
// - Inhibit config 2 blocks pulses and clears accumulated position.
// - Forward limit monitored at limit config 1; config 2 acts without alarm.
// - Reverse limit monitored at limit config 1; config 2 acts without alarm.
// - Alarm clear input resets alarm status and stored alarm record.
// - Position/speed switching: mode input active selects speed control.
// - Internal speed selection: mode input selects internal speed value.
// - Mode function four: mode input starts internal pulse motion.
// - Pulse formats: 0 pulse+direction, 1 forward/reverse, 2 quadrature.
// - Zero mark is an open-collector output to output common ground.
// - Encoder A/B outputs scaled by the encoder divider setting.
// - Encoder index pulse output as a differential pair.
package scio_pkg;

  // --------------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] SCIO_CTRL_OFF = 8'h00;
  localparam logic [7:0] SCIO_SPEED_OFF = 8'h04;
  localparam logic [7:0] SCIO_DIV_OFF = 8'h08;
  localparam logic [7:0] SCIO_STAT_OFF = 8'h0C;
  localparam logic [7:0] SCIO_POS_OFF = 8'h10;
  localparam logic [7:0] SCIO_IRQ_OFF = 8'h14;
  localparam logic [7:0] SCIO_MASK_OFF = 8'h18;
  localparam logic [7:0] SCIO_ALREC_OFF = 8'h1C;

  // --------------------------------------------------------------------------
  // Control register fields
  // --------------------------------------------------------------------------
  localparam int SCIO_C_OVR = 0;
  localparam int SCIO_C_INH = 1;
  localparam int SCIO_C_LIM = 3;
  localparam int SCIO_C_MODE = 5;
  localparam int SCIO_C_FMT = 8;
  localparam int SCIO_C_ALM = 10;
  localparam logic [31:0] SCIO_CTRL_RESET = 32'h0000_0000;

  // Interrupt bits
  localparam int SCIO_I_ALARM = 0;
  localparam int SCIO_I_FWDLIM = 1;
  localparam int SCIO_I_REVLIM = 2;
  localparam int SCIO_I_REFUSED = 3;
  localparam int SCIO_I_START = 4;
  localparam int SCIO_NIRQ = 5;

  // Mode function and format codes
  localparam logic [2:0] SCIO_MF_POSSPD = 3'h1;
  localparam logic [2:0] SCIO_MF_INTSPD = 3'h2;
  localparam logic [2:0] SCIO_MF_INTPULSE = 3'h4;
  localparam logic [1:0] SCIO_FMT_PS = 2'h0;
  localparam logic [1:0] SCIO_FMT_FR = 2'h1;
  localparam logic [1:0] SCIO_FMT_AB = 2'h2;

  // Timing: enable settle and divider reset
  localparam int SCIO_CLK_MHZ = 125;
  localparam int SCIO_EN_SETTLE_MS = 50;
  localparam int SCIO_EN_SETTLE_CYC = SCIO_EN_SETTLE_MS * 1000 * SCIO_CLK_MHZ;
  localparam logic [15:0] SCIO_DIV_RESET = 16'h0001;

endpackage : scio_pkg

// ### scio_edge.sv
// Edge detector for one synchronous input; previous value registered, rise and fall not.
// Assumes the input is already synchronous to pclk.
`timescale 1ns/10ps
module scio_edge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  output logic rise,
  output logic fall
);
  logic prev;

  // Previous value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= 1'b0;
    end else begin
      prev <= din;
    end
  end

  assign rise = din & ~prev;
  assign fall = ~din & prev;
endmodule : scio_edge

// ### scio_encdiv.sv
// Encoder A/B scaler: regenerates quadrature from divided step counts.
// Assumes step and direction pulses from the motor encoder count.
`timescale 1ns/10ps
module scio_encdiv (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic step,
  input wire logic dir_fwd,
  input wire logic [15:0] divider,
  output logic enc_a,
  output logic enc_b
);
  import scio_pkg::*;
  logic [15:0] cnt;
  logic [1:0] phase;

  // Divide steps; each wrap moves output phase one quarter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0000;
      phase <= 2'h0;
    end else if (step) begin
      if (cnt + 16'h0001 >= divider) begin
        cnt <= 16'h0000;
        phase <= dir_fwd ? phase + 2'h1 : phase - 2'h1;
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
  end

  // Gray sequence 00,01,11,10 gives A leading B when forward
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_a <= 1'b0;
      enc_b <= 1'b0;
    end else begin
      enc_a <= phase[1] ^ phase[0];
      enc_b <= phase[1];
    end
  end
endmodule : scio_encdiv

// ### scio_chk.sv
// Assertions on the servo command I/O block pins.
// Assumes a bind to scio_top; sees only its ports.
`timescale 1ns/10ps
module scio_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic pslverr,
  input wire logic servo_enable_input,
  input wire logic alarm_clear_input,
  input wire logic mode_input,
  input wire logic motor_enc_z,
  input wire logic drive_enabled,
  input wire logic speed_control,
  input wire logic internal_speed_sel,
  input wire logic internal_start,
  input wire logic servo_alarm,
  input wire logic encoder_a_output_p,
  input wire logic encoder_a_output_n,
  input wire logic encoder_b_output_p,
  input wire logic encoder_b_output_n,
  input wire logic encoder_index_output_p,
  input wire logic encoder_index_output_n,
  input wire logic zero_mark_oc_output,
  input wire logic zero_mark_oc_oe_n,
  input wire logic irq
);
  // ------------------------------------------------------------
  // Pin relations
  // ------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  zero_mark_a: assert property (zero_mark_oc_output == 1'b0 &&
    zero_mark_oc_oe_n == !$past(motor_enc_z)) else $error("zero mark");
  a_pair_a: assert property (
    encoder_a_output_p != encoder_a_output_n) else $error("A pair");
  b_pair_a: assert property (
    encoder_b_output_p != encoder_b_output_n) else $error("B pair");
  index_pair_a: assert property (
    encoder_index_output_p != encoder_index_output_n) else $error("Z pair");
  enable_follow_a: assert property (
    $past(servo_enable_input) |-> drive_enabled) else $error("enable");
  alarm_clear_a: assert property (
    $rose(alarm_clear_input) |-> ##[1:3] !servo_alarm) else $error("clr");
  speed_off_a: assert property (
    !mode_input [*3] |-> !speed_control) else $error("speed");
  intspd_off_a: assert property (
    !mode_input [*3] |-> !internal_speed_sel) else $error("int speed");
  start_pulse_a: assert property (
    internal_start |=> !internal_start) else $error("start");
  // Main scenarios reached
  start_c: cover property (internal_start);
  alarm_c: cover property (servo_alarm);
  irq_c: cover property (irq);
  slverr_c: cover property (psel && pslverr);
endmodule : scio_chk

// ### scio_ctl_model.sv
// Model of the motion controller sending command pulses.
// Assumes pulse lines idle low between commands.
`timescale 1ns/10ps
module scio_ctl_model #(
  parameter int HALF = 125
) (
  input wire logic pclk,
  output logic pulse_in,
  output logic sign_in
);
  import scio_pkg::*;
  initial pulse_in = 1'b0;
  initial sign_in = 1'b0;
  // Set one line, hold it half a period (500 kHz max)
  task automatic step(input logic a, input logic v);
    @(posedge pclk);
    if (a) pulse_in <= v;
    else sign_in <= v;
    repeat (HALF - 1) @(posedge pclk);
  endtask : step
  // Send n steps in format f, forward when fw
  task automatic send(input logic [1:0] f, input logic fw, input int n);
    for (int i = 0; i < n; i++) begin
      if (f == SCIO_FMT_PS) begin
        step(1'b0, !fw);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
      end else if (f == SCIO_FMT_FR) begin
        step(fw, 1'b1);
        step(fw, 1'b0);
      end else begin
        step(fw, 1'b1);
        step(!fw, 1'b1);
        step(fw, 1'b0);
        step(!fw, 1'b0);
      end
    end
    if (f == SCIO_FMT_PS) step(1'b0, 1'b0);
  endtask : send
endmodule : scio_ctl_model

// ### servo_command_io_logic_tb.sv
// Self-checking bench for the servo command I/O block.
// Assumes scio_top, scio_chk and scio_ctl_model compiled first.
`timescale 1ns/10ps
module servo_command_io_logic_tb;
  import scio_pkg::*;
  localparam int SETTLE = 20;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, err, pulse_in, sign_in, last, lastb;
  logic servo_enable_input = 0, command_pulse_inhibit = 0;
  logic forward_limit_input = 0, reverse_limit_input = 0;
  logic alarm_clear_input = 0, mode_input = 0, alarm_event = 0;
  logic motor_enc_a = 0, motor_enc_b = 0, motor_enc_z = 0;
  logic drive_enabled, settle_done, speed_control, internal_speed_sel;
  logic [15:0] speed_value;
  logic internal_start, servo_alarm, zero_mark_oc_output;
  logic zero_mark_oc_oe_n, irq, encoder_index_output_p;
  logic encoder_a_output_p, encoder_a_output_n, encoder_b_output_p;
  logic encoder_b_output_n, encoder_index_output_n;
  int failures = 0, checks = 0, cycles = 0, pos_e = 0, n, nb;
  scio_top #(.SETTLE_CYC(SETTLE)) DUT (.*);
  scio_ctl_model ctl (.pclk(pclk), .pulse_in(pulse_in), .sign_in(sign_in));
  // ------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ------------------------------------------------------------
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc
  // One APB transfer, held until pready at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask : rdc
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    rdc(SCIO_CTRL_OFF, SCIO_CTRL_RESET);
    rdc(SCIO_DIV_OFF, 32'(SCIO_DIV_RESET));
    apb(1'b0, 8'h20, 32'h0);
    chk(err, 1'b1);
    chk(r, 32'h0);
    $display("regs done");
  endtask : t_regs
  task automatic t_enable();
    apb(1'b1, SCIO_CTRL_OFF, 32'h1);
    cyc(3);
    chk(drive_enabled, 1'b1);
    apb(1'b1, SCIO_CTRL_OFF, 32'h0);
    cyc(3);
    chk(drive_enabled, 1'b0);
    servo_enable_input <= 1'b1;
    n = 0;
    while (settle_done !== 1'b1 && n < 99) begin
      cyc(1);
      n++;
    end
    chk(32'(n >= SETTLE - 1 && n <= SETTLE + 4), 32'h1);
    $display("enable done");
  endtask : t_enable
  // Both directions in every format; position read back
  task automatic t_pulse();
    for (int f = 0; f < 3; f++) begin
      apb(1'b1, SCIO_CTRL_OFF, 32'(f) << SCIO_C_FMT);
      ctl.send(2'(f), 1'b1, 3);
      ctl.send(2'(f), 1'b0, 1);
      cyc(4);
      pos_e += (f == 2) ? 8 : 2;
      rdc(SCIO_POS_OFF, 32'(pos_e));
    end
    $display("pulse done");
  endtask : t_pulse
  task automatic t_inhibit();
    command_pulse_inhibit <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, SCIO_CTRL_OFF, 32'(c) << SCIO_C_INH);
      ctl.send(SCIO_FMT_PS, 1'b1, 1);
      cyc(4);
      pos_e = (c == 0) ? pos_e + 1 : (c == 2) ? 0 : pos_e;
      rdc(SCIO_POS_OFF, 32'(pos_e));
    end
    command_pulse_inhibit <= 1'b0;
    $display("inhibit done");
  endtask : t_inhibit
  // Limits, interrupt and alarm clear
  task automatic t_limit();
    apb(1'b1, SCIO_CTRL_OFF, 32'h2 << SCIO_C_LIM);
    forward_limit_input <= 1'b1;
    ctl.send(SCIO_FMT_PS, 1'b1, 1);
    ctl.send(SCIO_FMT_PS, 1'b0, 1);
    cyc(4);
    rdc(SCIO_POS_OFF, 32'hFFFF_FFFF);
    chk(servo_alarm, 1'b0);
    chk(irq, 1'b0);
    rdc(SCIO_IRQ_OFF, 32'h0000_000A);
    apb(1'b1, SCIO_MASK_OFF, 32'h2);
    cyc(1);
    chk(irq, 1'b1);
    apb(1'b1, SCIO_IRQ_OFF, 32'hA);
    cyc(1);
    chk(irq, 1'b0);
    forward_limit_input <= 1'b0;
    apb(1'b1, SCIO_CTRL_OFF, 32'h1 << SCIO_C_LIM);
    reverse_limit_input <= 1'b1;
    cyc(4);
    chk(servo_alarm, 1'b1);
    rdc(SCIO_ALREC_OFF, 32'h0000_00FF);
    reverse_limit_input <= 1'b0;
    alarm_clear_input <= 1'b1;
    cyc(2);
    alarm_clear_input <= 1'b0;
    cyc(3);
    chk(servo_alarm, 1'b0);
    rdc(SCIO_ALREC_OFF, 32'h0);
    apb(1'b1, SCIO_CTRL_OFF, 32'h5A << SCIO_C_ALM);
    alarm_event <= 1'b1;
    cyc(1);
    alarm_event <= 1'b0;
    cyc(3);
    chk(servo_alarm, 1'b1);
    rdc(SCIO_ALREC_OFF, 32'h0000_005A);
    $display("limit done");
  endtask : t_limit
  task automatic t_mode();
    apb(1'b1, SCIO_SPEED_OFF, 32'h1234);
    apb(1'b1, SCIO_CTRL_OFF, 32'(SCIO_MF_POSSPD) << SCIO_C_MODE);
    mode_input <= 1'b1;
    cyc(3);
    chk(speed_control, 1'b1);
    mode_input <= 1'b0;
    apb(1'b1, SCIO_CTRL_OFF, 32'(SCIO_MF_INTSPD) << SCIO_C_MODE);
    chk(speed_control, 1'b0);
    mode_input <= 1'b1;
    cyc(3);
    chk(internal_speed_sel, 1'b1);
    chk(speed_value, 16'h1234);
    mode_input <= 1'b0;
    apb(1'b1, SCIO_CTRL_OFF, 32'(SCIO_MF_INTPULSE) << SCIO_C_MODE);
    mode_input <= 1'b1;
    n = 0;
    repeat (6) begin
      cyc(1);
      if (internal_start === 1'b1) n++;
    end
    chk(n, 1);
    mode_input <= 1'b0;
    $display("mode done");
  endtask : t_mode
  // Eight encoder edges at divider two give two A and two B toggles
  task automatic t_enc();
    apb(1'b1, SCIO_DIV_OFF, 32'h2);
    n = 0;
    nb = 0;
    for (int i = 0; i < 8; i++) begin
      motor_enc_a <= (i % 4 < 2);
      motor_enc_b <= (i % 4 == 1 || i % 4 == 2);
      last = encoder_a_output_p;
      lastb = encoder_b_output_p;
      cyc(4);
      if (encoder_a_output_p !== last) n++;
      if (encoder_b_output_p !== lastb) nb++;
    end
    chk(n, 2);
    chk(nb, 2);
    motor_enc_z <= 1'b1;
    cyc(4);
    chk(zero_mark_oc_oe_n, 1'b0);
    chk(encoder_index_output_p, 1'b1);
    motor_enc_z <= 1'b0;
    cyc(4);
    chk(zero_mark_oc_oe_n, 1'b1);
    $display("encoder done");
  endtask : t_enc
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_enable();
    t_pulse();
    t_inhibit();
    t_limit();
    t_mode();
    t_enc();
    stop_test();
  end
endmodule : servo_command_io_logic_tb
bind scio_top scio_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .pslverr(pslverr), .servo_enable_input(servo_enable_input),
  .alarm_clear_input(alarm_clear_input), .mode_input(mode_input),
  .motor_enc_z(motor_enc_z), .drive_enabled(drive_enabled),
  .speed_control(speed_control), .internal_speed_sel(internal_speed_sel),
  .internal_start(internal_start), .servo_alarm(servo_alarm),
  .encoder_a_output_p(encoder_a_output_p),
  .encoder_a_output_n(encoder_a_output_n),
  .encoder_b_output_p(encoder_b_output_p),
  .encoder_b_output_n(encoder_b_output_n),
  .encoder_index_output_p(encoder_index_output_p),
  .encoder_index_output_n(encoder_index_output_n),
  .zero_mark_oc_output(zero_mark_oc_output),
  .zero_mark_oc_oe_n(zero_mark_oc_oe_n), .irq(irq));
